// file: acs_pkg.sv
// Purpose: Shared constants and types for the conversion sync controller
// Assumes: One main clock of 40 MHz shared by all devices in a group
// Notes: Pin function codes are two-bit fields
package acs_pkg;

    // ==========================================================
    // Pin function codes
    localparam logic [1:0] SYNC_SEL_OFF = 2'h0;
    localparam logic [1:0] SYNC_SEL_STANDARD = 2'h1;
    localparam logic [1:0] SYNC_SEL_ALTERNATE = 2'h2;
    localparam logic [1:0] AUX_SEL_START = 2'h1;
    localparam logic [1:0] AUX_SEL_SYNC_OUT = 2'h1;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int SETTLE_TIME_US = 20;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_US * (CLK_FREQ_HZ / 1000000));
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Reset values
    localparam logic RDY_N_RESET = 1'b1;
    localparam logic SYNC_OUT_N_RESET = 1'b1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] sync_function_select;
        logic [1:0] aux_one_function_select;
        logic [1:0] aux_two_function_select;
    } acs_cfg_s;

    typedef struct packed {
        logic filter_reset;
        logic sequencer_reset;
        logic sequencer_advance;
        logic converting;
    } acs_ctl_s;

endpackage

// file: acs_sync2.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to mclk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module acs_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else if (ce) begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    assign pin_sync = sync_r;
endmodule

// file: acs_sync_ctrl.sv
// Purpose: Conversion start and multi-device sync control for a sigma-delta converter
// Assumes: Conversion engine and sequencer sit outside and obey the control outputs
// Notes: sync_input_pin is active low for reset; release on first rising edge seen high
`timescale 1ns/1ps
module acs_sync_ctrl #(
    parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYCLES,
    parameter int CHANNELS = 4,
    parameter int DATA_W = 24
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire acs_pkg::acs_cfg_s cfg,
    input wire logic [CHANNELS-1:0] channel_enable,
    input wire logic sync_input_pin,
    input wire logic aux_pin_two,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data,
    output logic aux_pin_one,
    output logic conversion_ready_n,
    output logic [DATA_W-1:0] data_out,
    output logic [$clog2(CHANNELS)-1:0] channel_out,
    output acs_pkg::acs_ctl_s ctl_out
);

    localparam int CW = $clog2(CHANNELS);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);

    // ==========================================================
    // Elaboration checks
    if (CHANNELS < 2) begin : g_bad_channels
        $error("acs_sync_ctrl: at least two channels are needed");
    end
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("acs_sync_ctrl: settle count must be at least one");
    end
    if (DATA_W < 1) begin : g_bad_width
        $error("acs_sync_ctrl: data width must be at least one");
    end
    if (acs_pkg::SYNC_STAGES != 2) begin : g_bad_stages
        $error("acs_sync_ctrl: the pin synchroniser has exactly two stages");
    end

    // ==========================================================
    // Input synchronisers
    logic sync_s;
    logic start_s;

    acs_sync2 #(.RESET_VAL(1'b1)) u_sync_in (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in(sync_input_pin),
        .pin_sync(sync_s)
    );

    acs_sync2 #(.RESET_VAL(1'b1)) u_start_in (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in(aux_pin_two),
        .pin_sync(start_s)
    );

    // ==========================================================
    // Helpers
    function automatic logic [CW-1:0] next_channel(input logic [CW-1:0] cur,
                                                   input logic [CHANNELS-1:0] en);
        logic [CW-1:0] pick;
        logic found;
        logic [CW-1:0] idx;
        pick = cur;
        found = 1'b0;
        for (int i = 1; i <= CHANNELS; i++) begin
            idx = CW'((int'(cur) + i) % CHANNELS);
            if (!found && en[idx]) begin
                pick = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // ==========================================================
    // Control state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_CONVERT,
        ST_WAIT_LOW,
        ST_WAIT_HIGH
    } acs_state_e;

    acs_state_e state_r, state_nxt;
    logic sync_d_r, sync_d_nxt;
    logic [SW-1:0] settle_r, settle_nxt;
    logic [CW-1:0] chan_r, chan_nxt;
    logic rdy_n_r, rdy_n_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic sync_out_r, sync_out_nxt;
    acs_pkg::acs_ctl_s ctl_r, ctl_nxt;

    logic std_mode;
    logic alt_mode;
    logic sync_fall;
    logic sync_rise;
    logic load_en;

    assign std_mode = (cfg.sync_function_select == acs_pkg::SYNC_SEL_STANDARD);
    assign alt_mode = (cfg.sync_function_select == acs_pkg::SYNC_SEL_ALTERNATE);
    assign sync_fall = sync_d_r && !sync_s;
    assign sync_rise = !sync_d_r && sync_s;

    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        chan_nxt = chan_r;
        rdy_n_nxt = rdy_n_r;
        load_en = 1'b0;
        ctl_nxt = '0;
        case (state_r)
            ST_IDLE: begin
                // Free running until a sync event arrives
                if (std_mode && sync_fall) begin
                    state_nxt = ST_HOLD;
                end else if (alt_mode && !sync_s) begin
                    state_nxt = ST_WAIT_HIGH;
                    chan_nxt = next_channel(chan_r, channel_enable);
                    ctl_nxt.sequencer_advance = 1'b1;
                end else if ((std_mode || alt_mode) && sync_rise) begin
                    state_nxt = ST_CONVERT;
                    settle_nxt = SW'(SETTLE_CYCLES);
                end
            end
            ST_HOLD: begin
                // Filter and sequencer held; configuration untouched
                ctl_nxt.filter_reset = 1'b1;
                ctl_nxt.sequencer_reset = 1'b1;
                chan_nxt = '0;
                rdy_n_nxt = 1'b1;
                if (!std_mode) begin
                    state_nxt = ST_IDLE;
                end else if (sync_s) begin
                    // Released on the first edge that samples the pin high
                    state_nxt = ST_CONVERT;
                    settle_nxt = SW'(SETTLE_CYCLES);
                    ctl_nxt.filter_reset = 1'b0;
                    ctl_nxt.sequencer_reset = 1'b0;
                    ctl_nxt.converting = 1'b1;
                end
            end
            ST_CONVERT: begin
                ctl_nxt.converting = 1'b1;
                if (std_mode && sync_fall) begin
                    state_nxt = ST_HOLD;
                    ctl_nxt.converting = 1'b0;
                end else if (settle_r > SW'(1)) begin
                    settle_nxt = settle_r - SW'(1);
                    if (result_valid) begin
                        rdy_n_nxt = 1'b1;
                    end
                end else if (result_valid) begin
                    // Full settling elapsed: result loaded, ready falls
                    load_en = 1'b1;
                    rdy_n_nxt = 1'b0;
                    ctl_nxt.converting = 1'b0;
                    if (alt_mode && !sync_s) begin
                        chan_nxt = next_channel(chan_r, channel_enable);
                        ctl_nxt.sequencer_advance = 1'b1;
                        state_nxt = ST_WAIT_HIGH;
                    end else if (alt_mode) begin
                        state_nxt = ST_WAIT_LOW;
                    end else begin
                        state_nxt = ST_WAIT_LOW;
                    end
                end
            end
            ST_WAIT_LOW: begin
                if (std_mode && sync_fall) begin
                    state_nxt = ST_HOLD;
                end else if (alt_mode && !sync_s) begin
                    chan_nxt = next_channel(chan_r, channel_enable);
                    ctl_nxt.sequencer_advance = 1'b1;
                    state_nxt = ST_WAIT_HIGH;
                end else if (!std_mode && !alt_mode) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WAIT_HIGH: begin
                // Next channel selected; conversion waits for the pin to rise
                if (!alt_mode) begin
                    state_nxt = ST_IDLE;
                end else if (sync_s) begin
                    rdy_n_nxt = 1'b1;
                    state_nxt = ST_CONVERT;
                    settle_nxt = SW'(SETTLE_CYCLES);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            settle_r <= '0;
            chan_r <= '0;
            rdy_n_r <= acs_pkg::RDY_N_RESET;
            ctl_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
            chan_r <= chan_nxt;
            rdy_n_r <= rdy_n_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    // ==========================================================
    // Sync pin edge detector
    // Reset value matches the idle-high pin so no false edge follows reset
    always_comb begin
        sync_d_nxt = sync_s;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_d_r <= 1'b1;
        end else if (ce) begin
            sync_d_r <= sync_d_nxt;
        end
    end

    // ==========================================================
    // Sync output re-timing
    // Start input re-timed onto the main clock; idles high when not selected
    always_comb begin
        sync_out_nxt = acs_pkg::SYNC_OUT_N_RESET;
        if (cfg.aux_one_function_select == acs_pkg::AUX_SEL_SYNC_OUT &&
            cfg.aux_two_function_select == acs_pkg::AUX_SEL_START) begin
            sync_out_nxt = start_s;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out_r <= acs_pkg::SYNC_OUT_N_RESET;
        end else if (ce) begin
            sync_out_r <= sync_out_nxt;
        end
    end

    // ==========================================================
    // Result register
    // Loaded only when a settled result is accepted
    always_comb begin
        data_nxt = data_r;
        if (load_en) begin
            data_nxt = result_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= '0;
        end else if (ce) begin
            data_r <= data_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    assign aux_pin_one = sync_out_r;
    assign conversion_ready_n = rdy_n_r;
    assign data_out = data_r;
    assign channel_out = chan_r;
    assign ctl_out = ctl_r;
endmodule

// file: acs_sync_ctrl_asserts.sv
// Purpose: Checker for the conversion sync controller
// Assumes: ce held high
// Notes: Latencies follow the pin synchroniser
`timescale 1ns/1ps
module acs_sync_ctrl_asserts #(
    parameter int SETTLE_CYCLES = 4,
    parameter int CHANNELS = 4,
    parameter int DATA_W = 24
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire acs_pkg::acs_cfg_s cfg,
    input wire logic [CHANNELS-1:0] channel_enable,
    input wire logic sync_input_pin,
    input wire logic aux_pin_two,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data,
    input wire logic aux_pin_one,
    input wire logic conversion_ready_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [$clog2(CHANNELS)-1:0] channel_out,
    input wire acs_pkg::acs_ctl_s ctl_out
);
    logic [DATA_W-1:0] res_r;
    logic [DATA_W-1:0] res_nxt;
    logic sel_std;
    logic sel_off;
    logic aux_on;
    assign sel_std = cfg.sync_function_select == acs_pkg::SYNC_SEL_STANDARD;
    assign sel_off = cfg.sync_function_select inside {acs_pkg::SYNC_SEL_OFF, 2'h3};
    assign aux_on = cfg.aux_one_function_select == acs_pkg::AUX_SEL_SYNC_OUT
        && cfg.aux_two_function_select == acs_pkg::AUX_SEL_START;
    // Last result offered by the engine
    always_comb res_nxt = result_valid ? result_data : res_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) res_r <= '0;
        else res_r <= res_nxt;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    hold_entry_a: assert property ($fell(sync_input_pin) && sel_std
        ##1 !sync_input_pin [*2] |-> ##[1:2] ctl_out.filter_reset && ctl_out.sequencer_reset)
        else $error("sync reset missing");
    hold_stay_a: assert property (ctl_out.filter_reset && !sync_input_pin
        |=> ctl_out.filter_reset) else $error("sync reset dropped early");
    sync_release_a: assert property ($rose(sync_input_pin) && ctl_out.filter_reset
        |-> ##[2:3] !ctl_out.filter_reset && ctl_out.converting) else $error("late release");
    code_ignore_a: assert property (sel_off [*4] |-> !ctl_out.filter_reset)
        else $error("sync not ignored");
    ready_cause_a: assert property ($fell(conversion_ready_n)
        |-> $past(result_valid) || $past(result_valid, 2)) else $error("ready without result");
    data_load_a: assert property ($fell(conversion_ready_n)
        |-> ##[0:1] data_out == res_r) else $error("data not loaded");
    sync_out_a: assert property (aux_on [*3] |-> aux_pin_one == $past(aux_pin_two, 3))
        else $error("sync out not retimed");
    sync_idle_a: assert property (!aux_on [*2] |-> aux_pin_one)
        else $error("sync out not idle");
    seq_advance_a: assert property ($changed(channel_out) && !ctl_out.sequencer_reset
        |-> ctl_out.sequencer_advance) else $error("channel moved without advance");
endmodule
bind acs_sync_ctrl acs_sync_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .CHANNELS(CHANNELS),
    .DATA_W(DATA_W)) u_acs_sync_ctrl_asserts (.mclk(mclk), .rst_n(rst_n), .ce(ce), .cfg(cfg),
    .channel_enable(channel_enable), .sync_input_pin(sync_input_pin),
    .aux_pin_two(aux_pin_two), .result_valid(result_valid), .result_data(result_data),
    .aux_pin_one(aux_pin_one), .conversion_ready_n(conversion_ready_n),
    .data_out(data_out), .channel_out(channel_out), .ctl_out(ctl_out));

// file: acs_host_model.sv
// Purpose: Host driving the active-low sync pin
// Assumes: Shares mclk with the device
// Notes: Pin edges fall on mclk falling edges
`timescale 1ns/1ps
module acs_host_model (
    input wire logic mclk,
    output logic sync_pin
);
    int low_cnt = 0;
    initial sync_pin = 1'b1;
    always @(posedge mclk) low_cnt <= sync_pin ? 0 : low_cnt + 1;
    task automatic drop();
        @(negedge mclk);
        sync_pin = 1'b0;
    endtask
    task automatic raise();
        while (low_cnt < 2) @(negedge mclk);
        @(negedge mclk);
        sync_pin = 1'b1;
    endtask
endmodule

// file: test_adc_conversion_sync_control.sv
// Purpose: Self-checking bench for the conversion sync controller
// Assumes: ce held high, settle count shortened
// Notes: Ready falls are matched against a queue of results
`timescale 1ns/1ps
module test_adc_conversion_sync_control;
    localparam int SC = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    acs_pkg::acs_cfg_s cfg = '0;
    logic [3:0] en = 4'h1;
    logic aux2 = 1'b1;
    logic rv = 1'b0;
    logic [23:0] rd = 24'h0;
    logic sync_pin, aux1, rdy_n;
    logic [23:0] dout;
    logic [1:0] ch;
    logic [1:0] exp_ch;
    acs_pkg::acs_ctl_s ctl;
    logic [23:0] exp_q[$];
    logic pr = 1'b1;
    logic f1 = 1'b0;
    logic f2 = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    always #12.5 mclk = ~mclk;
    acs_host_model u_acs_host_model (.mclk(mclk), .sync_pin(sync_pin));
    acs_sync_ctrl #(.SETTLE_CYCLES(SC), .CHANNELS(4), .DATA_W(24)) u_acs_sync_ctrl (
        .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .cfg(cfg), .channel_enable(en),
        .sync_input_pin(sync_pin), .aux_pin_two(aux2), .result_valid(rv), .result_data(rd),
        .aux_pin_one(aux1), .conversion_ready_n(rdy_n), .data_out(dout), .channel_out(ch),
        .ctl_out(ctl));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic result(input logic [23:0] d, input bit note);
        @(negedge mclk);
        rv = 1'b1;
        rd = d;
        if (note) exp_q.push_back(d);
        @(negedge mclk);
        rv = 1'b0;
    endtask
    // ==========================================================
    // Result watcher
    always @(negedge mclk) begin
        if (f2) begin
            if (exp_q.size() == 0) check(24'h0, 24'h1);
            else check(dout, exp_q.pop_front());
        end
        pr <= rdy_n;
        f1 <= pr === 1'b1 && rdy_n === 1'b0;
        f2 <= f1;
    end
    initial begin
        tick(4000);
        mismatches++;
        end_sim();
    end
    // ==========================================================
    // Tests
    initial begin
        void'($urandom(35151));
        tick(16);
        rst_n = 1'b1;
        tick(2);
        for (int i = 0; i < 2; i++) begin
            cfg.sync_function_select = i ? 2'h3 : acs_pkg::SYNC_SEL_OFF;
            u_acs_host_model.drop();
            tick(5);
            check(24'(ctl.filter_reset), 24'h0);
            u_acs_host_model.raise();
            tick(3);
        end
        $display("test ignore done");
        cfg.sync_function_select = acs_pkg::SYNC_SEL_STANDARD;
        u_acs_host_model.drop();
        tick(6);
        check(24'({ctl.filter_reset, ctl.sequencer_reset}), 24'h3);
        u_acs_host_model.raise();
        tick(4);
        check(24'({ctl.filter_reset, ctl.converting}), 24'h1);
        result(24'($urandom), 1'b0);
        tick(2);
        check(24'(rdy_n), 24'h1);
        tick(SC);
        result(24'($urandom), 1'b1);
        tick(2);
        check(24'(rdy_n), 24'h0);
        $display("test standard done");
        u_acs_host_model.drop();
        u_acs_host_model.raise();
        tick(4);
        cfg.sync_function_select = acs_pkg::SYNC_SEL_ALTERNATE;
        en = 4'hF;
        exp_ch = 2'h0;
        for (int i = 0; i < 3; i++) begin
            u_acs_host_model.drop();
            tick(SC + 2);
            result(24'($urandom), 1'b1);
            exp_ch++;
            tick(3);
            check(24'({rdy_n, ch}), 24'(exp_ch));
            u_acs_host_model.raise();
            tick(4);
            check(24'(rdy_n), 24'h1);
        end
        $display("test alternate done");
        cfg.aux_one_function_select = acs_pkg::AUX_SEL_SYNC_OUT;
        cfg.aux_two_function_select = acs_pkg::AUX_SEL_START;
        for (int i = 0; i < 8; i++) begin
            aux2 = 1'($urandom);
            tick(3);
            check(24'(aux1), 24'(aux2));
        end
        cfg.aux_one_function_select = 2'h0;
        aux2 = 1'b0;
        tick(3);
        check(24'(aux1), 24'h1);
        rst_n = 1'b0;
        tick(2);
        check(24'({aux1, rdy_n, ctl}), 24'h30);
        rst_n = 1'b1;
        $display("test sync out done");
        check(24'(exp_q.size()), 24'h0);
        end_sim();
    end
endmodule
